// File: common/rtcr_pkg.sv
package rtcr_pkg;

  localparam int ADDR_W = 17;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;

  // Register indices; byte address is four times the index
  localparam logic [14:0] IDX_REG9_SLEEP_CONTROL = 15'h4082;
  localparam logic [14:0] IDX_REG10_CONTROL = 15'h4083;
  localparam logic [14:0] IDX_REG10_ON_CONTROL = 15'h4084;
  localparam logic [14:0] IDX_IRQ_STATUS = 15'h4090;
  localparam logic [14:0] IDX_IRQ_MASK = 15'h4091;
  localparam logic [14:0] IDX_REG10_STATE = 15'h4092;

  // Writable bits per register; all others read zero
  localparam logic [15:0] MASK_REG9_SLEEP = 16'h001f;
  localparam logic [15:0] MASK_REG10_CONTROL = 16'hdfc0;
  localparam logic [15:0] MASK_REG10_ON = 16'he11f;
  localparam logic [15:0] MASK_IRQ = 16'h0001;

  localparam logic [15:0] RST_REG9_SLEEP = 16'h0000;
  localparam logic [15:0] RST_REG10_CONTROL = 16'h0200;
  localparam logic [15:0] RST_REG10_ON = 16'h0000;
  localparam logic [15:0] RST_IRQ = 16'h0000;

  localparam int IRQ_UV_BIT = 0;
  localparam int STATE_EN_BIT = 2;
  localparam int STATE_MV_LSB = 4;

  localparam logic [1:0] ACT_IGNORE = 2'h0;
  localparam logic [1:0] ACT_SHUTDOWN = 2'h1;
  localparam logic [1:0] ACT_DEV_RESET = 2'h2;

  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_HC1 = 2'h1;
  localparam logic [1:0] SRC_HC2 = 2'h2;
  localparam logic [1:0] SRC_EITHER = 2'h3;

  localparam logic [1:0] HWM_OFF = 2'h1;
  localparam logic [1:0] HWM_ON_MODE = 2'h3;

  localparam logic [2:0] SLOT_NEVER = 3'h0;
  localparam logic [2:0] SLOT_LAST = 3'h5;
  localparam logic [2:0] SLOT_HWEN1 = 3'h6;
  localparam logic [2:0] SLOT_HWEN2 = 3'h7;
  localparam logic [2:0] SLEEP_SLOT_BASE = 3'h6;

  localparam logic [4:0] VCODE_COARSE = 5'h0d;
  localparam logic [11:0] MV_BASE_FINE = 12'h3e8;
  localparam logic [11:0] MV_STEP_FINE = 12'h032;
  localparam logic [11:0] MV_BASE_COARSE = 12'h6a4;
  localparam logic [11:0] MV_STEP_COARSE = 12'h064;

  typedef enum logic [1:0] {
    RTCR_OFF = 2'b00,
    RTCR_ON = 2'b01,
    RTCR_SLEEP = 2'b11,
    RTCR_FAULT = 2'b10
  } rtcr_state_t;

  typedef struct packed {
    logic [1:0] uv_action;
    logic pad13;
    logic [1:0] hw_ctrl_source;
    logic hw_ctrl_voltage_source;
    logic [1:0] hw_ctrl_op_mode;
    logic output_float_when_off;
    logic switch_operation;
    logic [5:0] pad0;
  } rtcr_ctrl_t;

  typedef struct packed {
    logic [2:0] on_enable_slot;
    logic [3:0] pad9;
    logic on_op_mode;
    logic [2:0] pad5;
    logic [4:0] on_voltage_code;
  } rtcr_on_ctrl_t;

endpackage

// File: verilog/rtcr_vcode_to_mv.sv
`timescale 1ns/1ps
module rtcr_vcode_to_mv (
  input wire logic [4:0] code,
  output logic [11:0] mv
);
  // Fine 50 mV steps up to 0Ch, coarse 100 mV steps from 0Dh
  always_comb begin
    if (code < rtcr_pkg::VCODE_COARSE) begin
      mv = rtcr_pkg::MV_BASE_FINE + 12'(code) * rtcr_pkg::MV_STEP_FINE;
    end else begin
      mv = rtcr_pkg::MV_BASE_COARSE +
           12'(code - rtcr_pkg::VCODE_COARSE) * rtcr_pkg::MV_STEP_COARSE;
    end
  end
endmodule

// File: verilog/rtcr_regs.sv
// Function
// RULE_01 - An undervoltage is ignored, shuts this regulator down, or resets the device per a 2-bit action code.
// RULE_02 - Every undervoltage detected by this regulator raises an interrupt whatever the action code.
// RULE_03 - A 2-bit source field picks no input, control one, control two, or either as hardware control.
// RULE_04 - Under hardware control the voltage comes from the ON code, or from the SLEEP code when the select bit is set.
// RULE_05 - Under hardware control the mode field gives low power for 00 and 10, off for 01, and the ON mode bit for 11.
// RULE_06 - A disabled output is discharged unless the float bit is set, and a separate bit selects switch operation.
// RULE_07 - The ON slot field enables never, in startup timeslots 1 to 5, or by hardware enable one or two.
// RULE_08 - In the ON state the ON mode bit picks normal mode at 0 and low-power mode at 1.
// RULE_09 - The ON voltage code maps 1.00 V to 1.60 V in 50 mV steps, then 1.70 V to 3.50 V in 100 mV steps.
// RULE_10 - The preceding regulator's SLEEP voltage code uses the same voltage mapping.
// RULE_11 - For a hardware-enabled regulator, sleep slot codes 001 to 101 choose the timeslot of entry into SLEEP.
// RULE_12 - Undefined register bits read as zero and writes to them have no effect.
`timescale 1ns/1ps
module rtcr_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic [16:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic hw_ctrl1,
  input wire logic hw_ctrl2,
  input wire logic hw_enable1,
  input wire logic hw_enable2,
  input wire logic [2:0] start_slot,
  input wire logic [2:0] sleep_slot_now,
  input wire logic [2:0] sleep_slot,
  input wire logic [4:0] sleep_voltage_code,
  input wire logic undervoltage,
  output logic reg_enable,
  output logic [4:0] reg_voltage_code,
  output logic [11:0] reg_voltage_mv,
  output logic reg_low_power,
  output logic reg_discharge,
  output logic reg_switch_mode,
  output logic [4:0] prior_sleep_voltage_code,
  output logic [11:0] prior_sleep_mv,
  output logic device_reset_req,
  output logic irq
);

  logic [15:0] reg9_sleep_control;
  logic [15:0] reg10_control;
  logic [15:0] reg10_on_control;
  logic [15:0] irq_status;
  logic [15:0] irq_mask;
  rtcr_pkg::rtcr_state_t state;
  rtcr_pkg::rtcr_state_t next_state;
  rtcr_pkg::rtcr_ctrl_t ctrl;
  rtcr_pkg::rtcr_on_ctrl_t on_ctrl;
  logic [14:0] index;
  logic wr_take;
  logic on_ctrl_wr;
  logic uv_d;
  logic uv_rise;
  logic hwc_active;
  logic hw_assigned;
  logic hw_en_level;
  logic sleep_hit;
  logic [4:0] next_vcode;
  logic next_low_power;
  logic next_enable;
  logic [11:0] vcode_mv;
  logic [11:0] prior_mv;
  logic [31:0] next_readdata;

  function automatic logic [15:0] merge(input logic [15:0] cur, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{be[1]}}, {8{be[0]}}} & mask;
    merge = (cur & ~lanes) | (wd[15:0] & lanes);
  endfunction

  assign ctrl = rtcr_pkg::rtcr_ctrl_t'(reg10_control);
  assign on_ctrl = rtcr_pkg::rtcr_on_ctrl_t'(reg10_on_control);
  assign index = address[16:2];
  assign wr_take = write && !waitrequest;
  assign on_ctrl_wr = wr_take && (index == rtcr_pkg::IDX_REG10_ON_CONTROL);
  assign uv_rise = undervoltage && !uv_d && reg_enable;

  // Hardware control source selection
  always_comb begin
    case (ctrl.hw_ctrl_source) // RULE_03
      rtcr_pkg::SRC_HC1: hwc_active = hw_ctrl1;
      rtcr_pkg::SRC_HC2: hwc_active = hw_ctrl2;
      rtcr_pkg::SRC_EITHER: hwc_active = hw_ctrl1 || hw_ctrl2;
      default: hwc_active = 1'b0;
    endcase
  end

  assign hw_assigned = on_ctrl.on_enable_slot >= rtcr_pkg::SLOT_HWEN1; // RULE_07
  assign hw_en_level = (on_ctrl.on_enable_slot == rtcr_pkg::SLOT_HWEN1) ? hw_enable1 : hw_enable2;
  // Sleep code n acts in timeslot 6 - n
  assign sleep_hit = (sleep_slot != rtcr_pkg::SLOT_NEVER) && (sleep_slot <= rtcr_pkg::SLOT_LAST) &&
                     (sleep_slot_now == rtcr_pkg::SLEEP_SLOT_BASE - sleep_slot); // RULE_11

  // Avalon handshake: one wait cycle, then the transfer completes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else if (!waitrequest) begin
      waitrequest <= 1'b1;
    end else if (read || write) begin
      waitrequest <= 1'b0;
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    if (index == rtcr_pkg::IDX_REG9_SLEEP_CONTROL) begin
      next_readdata[15:0] = reg9_sleep_control & rtcr_pkg::MASK_REG9_SLEEP; // RULE_12
    end else if (index == rtcr_pkg::IDX_REG10_CONTROL) begin
      next_readdata[15:0] = reg10_control & rtcr_pkg::MASK_REG10_CONTROL; // RULE_12
    end else if (index == rtcr_pkg::IDX_REG10_ON_CONTROL) begin
      next_readdata[15:0] = reg10_on_control & rtcr_pkg::MASK_REG10_ON; // RULE_12
    end else if (index == rtcr_pkg::IDX_IRQ_STATUS) begin
      next_readdata[15:0] = irq_status;
    end else if (index == rtcr_pkg::IDX_IRQ_MASK) begin
      next_readdata[15:0] = irq_mask;
    end else if (index == rtcr_pkg::IDX_REG10_STATE) begin
      next_readdata[1:0] = state;
      next_readdata[rtcr_pkg::STATE_EN_BIT] = reg_enable;
      next_readdata[rtcr_pkg::STATE_MV_LSB +: 12] = reg_voltage_mv;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      readdata <= next_readdata;
    end
  end

  // Configuration registers; only defined bits are stored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg9_sleep_control <= rtcr_pkg::RST_REG9_SLEEP;
      reg10_control <= rtcr_pkg::RST_REG10_CONTROL;
      reg10_on_control <= rtcr_pkg::RST_REG10_ON;
      irq_mask <= rtcr_pkg::RST_IRQ;
    end else if (wr_take) begin
      if (index == rtcr_pkg::IDX_REG9_SLEEP_CONTROL) begin
        reg9_sleep_control <= merge(reg9_sleep_control, writedata, byteenable,
                                    rtcr_pkg::MASK_REG9_SLEEP); // RULE_12
      end else if (index == rtcr_pkg::IDX_REG10_CONTROL) begin
        reg10_control <= merge(reg10_control, writedata, byteenable,
                               rtcr_pkg::MASK_REG10_CONTROL); // RULE_12
      end else if (index == rtcr_pkg::IDX_REG10_ON_CONTROL) begin
        reg10_on_control <= merge(reg10_on_control, writedata, byteenable,
                                  rtcr_pkg::MASK_REG10_ON); // RULE_12
      end else if (index == rtcr_pkg::IDX_IRQ_MASK) begin
        irq_mask <= merge(irq_mask, writedata, byteenable, rtcr_pkg::MASK_IRQ);
      end
    end
  end

  // Sticky undervoltage flag, write one to clear; a new event wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_status <= rtcr_pkg::RST_IRQ;
    end else begin
      for (int i = 0; i < rtcr_pkg::REG_W; i++) begin
        if (i == rtcr_pkg::IRQ_UV_BIT && uv_rise) begin
          irq_status[i] <= 1'b1; // RULE_02
        end else if (wr_take && index == rtcr_pkg::IDX_IRQ_STATUS && byteenable[i / 8] &&
                     writedata[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      uv_d <= 1'b0;
    end else begin
      uv_d <= undervoltage;
    end
  end

  // Regulator enable sequencing
  always_comb begin
    next_state = state;
    case (state)
      rtcr_pkg::RTCR_OFF: begin
        if (hw_assigned && hw_en_level) begin
          next_state = rtcr_pkg::RTCR_ON; // RULE_07
        end else if (!hw_assigned && on_ctrl.on_enable_slot != rtcr_pkg::SLOT_NEVER &&
                     start_slot == on_ctrl.on_enable_slot) begin
          next_state = rtcr_pkg::RTCR_ON; // RULE_07
        end
      end
      rtcr_pkg::RTCR_ON: begin
        if (on_ctrl.on_enable_slot == rtcr_pkg::SLOT_NEVER) begin
          next_state = rtcr_pkg::RTCR_OFF;
        end else if (hw_assigned && !hw_en_level) begin
          next_state = rtcr_pkg::RTCR_OFF;
        end else if (sleep_hit) begin
          next_state = hw_assigned ? rtcr_pkg::RTCR_SLEEP : rtcr_pkg::RTCR_OFF; // RULE_11
        end
      end
      rtcr_pkg::RTCR_SLEEP: begin
        if (!hw_assigned || !hw_en_level) begin
          next_state = rtcr_pkg::RTCR_OFF;
        end else if (sleep_slot_now == rtcr_pkg::SLOT_NEVER) begin
          next_state = rtcr_pkg::RTCR_ON;
        end
      end
      default: begin
        if (on_ctrl_wr) begin
          next_state = rtcr_pkg::RTCR_OFF;
        end
      end
    endcase
    if (uv_rise && ctrl.uv_action == rtcr_pkg::ACT_SHUTDOWN) begin
      next_state = rtcr_pkg::RTCR_FAULT; // RULE_01
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= rtcr_pkg::RTCR_OFF;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      device_reset_req <= 1'b0;
    end else begin
      device_reset_req <= uv_rise && (ctrl.uv_action == rtcr_pkg::ACT_DEV_RESET); // RULE_01
    end
  end

  // Output voltage, mode and enable selection
  always_comb begin
    next_enable = (next_state == rtcr_pkg::RTCR_ON) || (next_state == rtcr_pkg::RTCR_SLEEP);
    next_vcode = on_ctrl.on_voltage_code;
    next_low_power = on_ctrl.on_op_mode; // RULE_08
    if (next_state == rtcr_pkg::RTCR_SLEEP) begin
      next_vcode = sleep_voltage_code;
      next_low_power = 1'b1;
    end else if (hwc_active) begin
      if (ctrl.hw_ctrl_voltage_source) begin
        next_vcode = sleep_voltage_code; // RULE_04
      end
      if (ctrl.hw_ctrl_op_mode == rtcr_pkg::HWM_OFF) begin
        next_enable = 1'b0; // RULE_05
      end
      if (ctrl.hw_ctrl_op_mode != rtcr_pkg::HWM_ON_MODE) begin
        next_low_power = 1'b1; // RULE_05
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_enable <= 1'b0;
      reg_voltage_code <= 5'h00;
      reg_low_power <= 1'b0;
      reg_discharge <= 1'b1;
      reg_switch_mode <= 1'b0;
    end else begin
      reg_enable <= next_enable;
      reg_voltage_code <= next_vcode;
      reg_low_power <= next_low_power;
      reg_discharge <= !next_enable && !ctrl.output_float_when_off; // RULE_06
      reg_switch_mode <= ctrl.switch_operation; // RULE_06
    end
  end

  rtcr_vcode_to_mv u_on_mv (
    .code(reg_voltage_code),
    .mv(vcode_mv)
  );

  rtcr_vcode_to_mv u_prior_mv (
    .code(reg9_sleep_control[4:0]),
    .mv(prior_mv)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_voltage_mv <= rtcr_pkg::MV_BASE_FINE;
      prior_sleep_voltage_code <= 5'h00;
      prior_sleep_mv <= rtcr_pkg::MV_BASE_FINE;
    end else begin
      reg_voltage_mv <= vcode_mv; // RULE_09
      prior_sleep_voltage_code <= reg9_sleep_control[4:0];
      prior_sleep_mv <= prior_mv; // RULE_10
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_UV_SHUTDOWN: assert property (uv_rise && ctrl.uv_action == rtcr_pkg::ACT_SHUTDOWN |=> // RULE_01
    state == rtcr_pkg::RTCR_FAULT ##1 !reg_enable)
    else $error("Shutdown action did not turn the regulator off");
  AST_UV_DEV_RESET: assert property (device_reset_req |-> // RULE_01
    $past(ctrl.uv_action) == rtcr_pkg::ACT_DEV_RESET && $past(undervoltage))
    else $error("Device reset request without an undervoltage reset action");
  AST_UV_IRQ: assert property (uv_rise |=> irq_status[rtcr_pkg::IRQ_UV_BIT]) // RULE_02
    else $error("Undervoltage did not set the interrupt flag");
  AST_HWC_VSEL: assert property (hwc_active && ctrl.hw_ctrl_voltage_source && // RULE_04
    state == rtcr_pkg::RTCR_ON && next_state == rtcr_pkg::RTCR_ON |=>
    reg_voltage_code == $past(sleep_voltage_code))
    else $error("Hardware control voltage select not followed");
  AST_HWC_OFF: assert property (hwc_active && ctrl.hw_ctrl_op_mode == rtcr_pkg::HWM_OFF // RULE_05
    && next_state != rtcr_pkg::RTCR_SLEEP |=> !reg_enable)
    else $error("Hardware control off mode left regulator on");
  AST_DISCHARGE: assert property (reg_discharge |-> !reg_enable) // RULE_06
    else $error("Output discharged while enabled");
  AST_SLOT_START: assert property (state == rtcr_pkg::RTCR_OFF && !hw_assigned && // RULE_07
    on_ctrl.on_enable_slot != rtcr_pkg::SLOT_NEVER && start_slot == on_ctrl.on_enable_slot
    && !uv_rise |=> state == rtcr_pkg::RTCR_ON && (reg_enable || $past(hwc_active)))
    else $error("Startup timeslot did not enable the regulator");
  AST_ON_MODE: assert property (state == rtcr_pkg::RTCR_ON && next_state == rtcr_pkg::RTCR_ON // RULE_08
    && !hwc_active |=> reg_low_power == $past(on_ctrl.on_op_mode))
    else $error("ON mode bit not applied");
  AST_MV_COARSE: assert property (reg_voltage_code == rtcr_pkg::VCODE_COARSE |=> // RULE_09
    reg_voltage_mv == rtcr_pkg::MV_BASE_COARSE)
    else $error("Code 0Dh does not give 1.70 V");
  AST_RSVD_ZERO: assert property (read && !waitrequest && // RULE_12
    index == rtcr_pkg::IDX_REG10_CONTROL |-> (readdata[15:0] & ~rtcr_pkg::MASK_REG10_CONTROL) == 16'h0000)
    else $error("Undefined control bits read nonzero");

  COV_FAULT: cover property (state == rtcr_pkg::RTCR_ON ##1 state == rtcr_pkg::RTCR_FAULT);
  COV_SLEEP: cover property (state == rtcr_pkg::RTCR_ON ##1 state == rtcr_pkg::RTCR_SLEEP);
  COV_IRQ: cover property (irq && uv_rise);

endmodule

// File: verification/rtcr_regs_bench.sv
`timescale 1ns/1ps
module rtcr_regs_bench;
  logic clk, rst, read, write, waitrequest;
  logic [16:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0] byteenable;
  logic hw_ctrl1, hw_ctrl2, hw_enable1, hw_enable2, undervoltage;
  logic [2:0] start_slot, sleep_slot_now, sleep_slot;
  logic [4:0] sleep_voltage_code, reg_voltage_code, prior_sleep_voltage_code;
  logic [11:0] reg_voltage_mv, prior_sleep_mv;
  logic reg_enable, reg_low_power, reg_discharge, reg_switch_mode, device_reset_req, irq;
  int n_errors, compares, p0;
  int pulses = 0;

  rtcr_regs i_dut (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .hw_ctrl1(hw_ctrl1), .hw_ctrl2(hw_ctrl2),
    .hw_enable1(hw_enable1), .hw_enable2(hw_enable2), .start_slot(start_slot),
    .sleep_slot_now(sleep_slot_now), .sleep_slot(sleep_slot),
    .sleep_voltage_code(sleep_voltage_code), .undervoltage(undervoltage),
    .reg_enable(reg_enable), .reg_voltage_code(reg_voltage_code),
    .reg_voltage_mv(reg_voltage_mv), .reg_low_power(reg_low_power),
    .reg_discharge(reg_discharge), .reg_switch_mode(reg_switch_mode),
    .prior_sleep_voltage_code(prior_sleep_voltage_code), .prior_sleep_mv(prior_sleep_mv),
    .device_reset_req(device_reset_req), .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    if (device_reset_req === 1'b1) pulses <= pulses + 1;
  end

  task automatic finish_test();
    if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic xfer(input logic is_wr, input logic [14:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= {idx, 2'b00};
    writedata <= {16'h0000, d};
    read <= ~is_wr;
    write <= is_wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    if (n >= 100) n_errors++;
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [14:0] idx, input logic [15:0] d);
    xfer(1'b1, idx, d);
    tick(3);
  endtask

  task automatic rdchk(input logic [14:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 16'h0000);
    chk(rd, exp);
  endtask

  function automatic logic [11:0] mv_of(input logic [4:0] c);
    if (c < 5'h0d) return 12'h3e8 + 12'(c) * 12'h032;
    return 12'h6a4 + 12'(c - 5'h0d) * 12'h064;
  endfunction

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    finish_test();
  end

  initial begin
    rst = 1'b1; read = 1'b0; write = 1'b0; address = 17'h00000;
    writedata = 32'h0; byteenable = 4'h3; hw_ctrl1 = 1'b0; hw_ctrl2 = 1'b0;
    hw_enable1 = 1'b0; hw_enable2 = 1'b0; undervoltage = 1'b0; start_slot = 3'h0;
    sleep_slot_now = 3'h0; sleep_slot = 3'h0; sleep_voltage_code = 5'h1a;
    n_errors = 0; compares = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk(rtcr_pkg::IDX_REG10_CONTROL, 32'h00000200);
    rdchk(rtcr_pkg::IDX_REG10_ON_CONTROL, 32'h0);
    rdchk(rtcr_pkg::IDX_REG9_SLEEP_CONTROL, 32'h0);
    chk(32'(reg_discharge), 32'h1);
    wr(rtcr_pkg::IDX_REG10_CONTROL, 16'hffff);
    rdchk(rtcr_pkg::IDX_REG10_CONTROL, 32'h0000dfc0);
    wr(rtcr_pkg::IDX_REG10_ON_CONTROL, 16'hffff);
    rdchk(rtcr_pkg::IDX_REG10_ON_CONTROL, 32'h0000e11f);
    wr(rtcr_pkg::IDX_REG9_SLEEP_CONTROL, 16'hffff);
    rdchk(rtcr_pkg::IDX_REG9_SLEEP_CONTROL, 32'h0000001f);
    wr(15'h4088, 16'hffff);
    rdchk(15'h4088, 32'h0);
    // Float and switch bits while the regulator is off
    wr(rtcr_pkg::IDX_REG10_CONTROL, 16'h0280);
    chk(32'(reg_discharge), 32'h0);
    wr(rtcr_pkg::IDX_REG10_CONTROL, 16'h0240);
    chk({reg_discharge, reg_switch_mode}, 32'h3);
    wr(rtcr_pkg::IDX_REG10_CONTROL, 16'h0200);
    // Startup timeslots: not before the slot, on in the slot
    for (int s = 1; s <= 5; s++) begin
      wr(rtcr_pkg::IDX_REG10_ON_CONTROL, 16'h0000);
      start_slot <= 3'(s - 1);
      wr(rtcr_pkg::IDX_REG10_ON_CONTROL, {3'(s), 13'h0000});
      chk(32'(reg_enable), 32'h0);
      start_slot <= 3'(s);
      tick(3);
      chk(32'(reg_enable), 32'h1);
    end
    wr(rtcr_pkg::IDX_REG10_ON_CONTROL, 16'h0000);
    chk(32'(reg_enable), 32'h0);
    start_slot <= 3'h0;
    // Hardware enables: the other input first, then its own
    for (int k = 0; k < 2; k++) begin
      wr(rtcr_pkg::IDX_REG10_ON_CONTROL, (k == 0) ? 16'hc000 : 16'he000);
      {hw_enable2, hw_enable1} <= (k == 0) ? 2'b10 : 2'b01;
      tick(3);
      chk(32'(reg_enable), 32'h0);
      {hw_enable2, hw_enable1} <= (k == 0) ? 2'b01 : 2'b10;
      tick(3);
      chk(32'(reg_enable), 32'h1);
    end
    {hw_enable2, hw_enable1} <= 2'b01;
    for (int c = 0; c < 32; c++) begin
      wr(rtcr_pkg::IDX_REG10_ON_CONTROL, 16'hc000 | 16'(c));
      wr(rtcr_pkg::IDX_REG9_SLEEP_CONTROL, 16'(c));
      chk({reg_voltage_code, reg_voltage_mv}, {15'h0, 5'(c), mv_of(5'(c))});
      chk({prior_sleep_voltage_code, prior_sleep_mv}, {15'h0, 5'(c), mv_of(5'(c))});
    end
    wr(rtcr_pkg::IDX_REG10_ON_CONTROL, 16'hc105);
    chk(32'(reg_low_power), 32'h1);
    wr(rtcr_pkg::IDX_REG10_ON_CONTROL, 16'hc005);
    chk(32'(reg_low_power), 32'h0);
    // Hardware control mode field with control input one asserted
    hw_ctrl1 <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(rtcr_pkg::IDX_REG10_CONTROL, 16'h0800 | 16'(m << 8));
      chk(32'(reg_enable), 32'(m != 1));
      if (m != 1) chk(32'(reg_low_power), 32'(m != 3));
    end
    wr(rtcr_pkg::IDX_REG10_CONTROL, 16'h0f00);
    chk(32'(reg_voltage_code), 32'h1a);
    hw_ctrl1 <= 1'b0;
    tick(3);
    chk(32'(reg_voltage_code), 32'h05);
    // Source field: which control inputs turn the regulator off
    for (int src = 0; src < 4; src++) begin
      for (int h = 1; h < 3; h++) begin
        wr(rtcr_pkg::IDX_REG10_CONTROL, 16'(src << 11) | 16'h0100);
        {hw_ctrl2, hw_ctrl1} <= 2'(h);
        tick(3);
        chk(32'(reg_enable), 32'(!(src == 3 || src == h)));
        {hw_ctrl2, hw_ctrl1} <= 2'b00;
        tick(3);
      end
    end
    // Undervoltage actions, interrupt raised for each
    wr(rtcr_pkg::IDX_IRQ_MASK, 16'h0001);
    for (int a = 0; a < 3; a++) begin
      wr(rtcr_pkg::IDX_REG10_ON_CONTROL, 16'hc005);
      wr(rtcr_pkg::IDX_REG10_CONTROL, 16'(a << 14) | 16'h0200);
      p0 = pulses;
      undervoltage <= 1'b1;
      tick(4);
      undervoltage <= 1'b0;
      chk(32'(irq), 32'h1);
      rdchk(rtcr_pkg::IDX_IRQ_STATUS, 32'h1);
      chk(32'(pulses - p0), 32'(a == 2));
      if (a < 2) chk(32'(reg_enable), 32'(a == 0));
      wr(rtcr_pkg::IDX_IRQ_STATUS, 16'h0001);
      chk(32'(irq), 32'h0);
    end
    wr(rtcr_pkg::IDX_REG10_ON_CONTROL, 16'hc005);
    wr(rtcr_pkg::IDX_REG10_CONTROL, 16'h0200);
    wr(rtcr_pkg::IDX_IRQ_MASK, 16'h0000);
    undervoltage <= 1'b1;
    tick(4);
    undervoltage <= 1'b0;
    chk(32'(irq), 32'h0);
    rdchk(rtcr_pkg::IDX_IRQ_STATUS, 32'h1);
    wr(rtcr_pkg::IDX_IRQ_STATUS, 16'h0001);
    // Sleep entry in timeslot 5 for a hardware-enabled regulator
    sleep_slot <= 3'h1;
    sleep_slot_now <= 3'h4;
    tick(3);
    chk(32'(reg_voltage_code), 32'h05);
    sleep_slot_now <= 3'h5;
    tick(3);
    chk({reg_enable, reg_low_power, reg_voltage_code}, 32'h7a);
    sleep_slot_now <= 3'h0;
    tick(3);
    chk({reg_enable, reg_voltage_code}, 32'h25);
    finish_test();
  end
endmodule
